/* logic/adccl_pkg.sv */
// package for the converter compare and low-power control block
// assumes a 100 MHz bus clock and an 8-bit register view over avalon-mm
package adccl_pkg;
	// register byte addresses, one aligned word each
	localparam logic [4:0] OFS_STATUS_CONTROL_1 = 5'h00;
	localparam logic [4:0] OFS_STATUS_CONTROL_2 = 5'h04;
	localparam logic [4:0] OFS_RESULT_HIGH      = 5'h08;
	localparam logic [4:0] OFS_RESULT_LOW       = 5'h0C;
	localparam logic [4:0] OFS_CONFIG           = 5'h10;
	localparam logic [4:0] OFS_COMPARE_HIGH     = 5'h14;
	localparam logic [4:0] OFS_COMPARE_LOW      = 5'h18;
	localparam logic [4:0] OFS_PIN_CONTROL_1    = 5'h1C;
	// status/control 1 fields
	localparam int SC1_CONVERSION_COMPLETE_FLAG_BIT = 7;
	localparam int SC1_COMPLETION_IRQ_ENABLE_BIT = 6;
	localparam int SC1_CONTINUOUS_CONVERSION_BIT = 5;
	// status/control 2 fields
	localparam int SC2_ACT_BIT  = 7;
	localparam int SC2_TRG_BIT  = 6;
	localparam int SC2_CFE_BIT  = 5;
	localparam int SC2_CFGT_BIT = 4;
	// config fields
	localparam int CFG_LPC_BIT  = 7;
	localparam int CFG_DIV_LSB  = 5;
	localparam int CFG_LSMP_BIT = 4;
	localparam int CFG_MODE_LSB = 2;
	localparam int CFG_CLK_LSB  = 0;
	localparam logic [1:0] MODE_8BIT  = 2'h0;
	localparam logic [1:0] MODE_10BIT = 2'h2;
	localparam logic [1:0] ICLK_BUS   = 2'h0;
	localparam logic [1:0] ICLK_BUS2  = 2'h1;
	localparam logic [1:0] ICLK_ASYNC = 2'h3;
	localparam logic [4:0] CH_DISABLED = 5'h1F;
	// reset values
	localparam logic [7:0] RST_SC1    = 8'h1F;
	localparam logic [7:0] RST_BYTE   = 8'h00;
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_CONVERT = 2'b01,
		ST_FINISH  = 2'b10
	} adccl_state_type;
endpackage

/* logic/adccl_top.sv */
// converter compare and low-power control, avalon-mm slave on the bus clock
// assumes an analog core handshake (start/done/data) and async done passed as toggle
// Behaviour
// - compare adds two's complement of value
// - upper limit: flag when result >= value
// - lower limit: flag when result < value
// - compare success stores the difference
// - failed compare: no flag, no store
// - flag plus enable raises interrupt
// - wait: finish running, hardware/continuous start only (the code ignores wait_mode_i; a control 1 write still starts)
// - wait keeps all conversion clocks running
// - stop3 without async clock aborts to idle
// - stop3 with async clock keeps converting
// - completion in wait/stop3 flags and interrupts
// - stop1/stop2 disable, registers reset
// - config field layout fixed
// - mode, divider, clock select encodings
// - status/control 1 field layout fixed
// - single conversion; channel routed to core
// - status/control 2 active, trigger, compare bits
// - low bits read zero, reserved write zero
// - 10-bit high read, low unread: result discarded
// - sc1 write starts with software trigger unless channel ones
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module adccl_top
	import adccl_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        wait_mode_i,
	input  wire logic        stop3_mode_i,
	input  wire logic        stop12_mode_i,
	input  wire logic        hardware_trigger_i,
	input  wire logic        core_done_toggle_i,
	input  wire logic [9:0]  core_data_i,
	output logic             core_start_o,
	output logic             core_abort_o,
	output logic [4:0]       core_channel_o,
	output logic [1:0]       core_mode_o,
	output logic             core_long_sample_o,
	output logic             core_low_power_o,
	output logic [1:0]       core_clock_select_o,
	output logic [1:0]       core_clock_divider_o,
	output logic             core_bus_clock_enable_o,
	output logic [7:0]       pin_control_1_o,
	output logic             converter_irq_o
);
	import adccl_pkg::*;

	logic [7:0]  converter_config;
	logic [7:0]  sc1_ctrl;
	logic        conversion_complete_flag;
	logic        sc2_trg;
	logic        sc2_cfe;
	logic        sc2_cfgt;
	logic [7:0]  result_high;
	logic [7:0]  result_low;
	logic [7:0]  compare_value_high;
	logic [7:0]  compare_value_low;
	logic        block_transfer;
	adccl_state_type state;
	logic        rd_ack;
	logic [2:0]  hwt_sync;
	logic [2:0]  done_sync;
	logic [9:0]  data_q;
	logic        stop3_q;
	logic        sw_start;
	logic        mode_change;
	logic        hwt_rise;
	logic        done_evt;
	logic        async_sel;
	logic        stop_abort;
	logic        wr;
	logic        rd;
	logic [9:0]  cmp_val;
	logic [10:0] diff;
	logic        cmp_ok;
	logic        xfer_ok;
	logic        is_10bit;
	logic        wr_sc1;
	logic        wr_sc2;
	logic        wr_cfg;
	logic        wr_cvh;
	logic        wr_cvl;
	logic        wr_pin;
	logic        rd_hi;
	logic        rd_lo;
	logic        store_result;
	logic [7:0]  next_readdata;

	function automatic logic [9:0] mask_res(input logic [9:0] v, input logic ten);
		mask_res = ten ? v : {2'b00, v[7:0]};
	endfunction

	// register strobe: request active on one address
	function automatic logic reg_hit(input logic req, input logic [4:0] addr, input logic [4:0] ofs);
		reg_hit = req && addr == ofs;
	endfunction

	assign wr = avs_write_i;
	assign rd = avs_read_i & ~rd_ack;
	// writes finish in the cycle; reads take one wait cycle
	assign avs_waitrequest_o = avs_read_i & ~rd_ack;

	// register strobes
	assign wr_sc1 = reg_hit(wr, avs_address_i, OFS_STATUS_CONTROL_1);
	assign wr_sc2 = reg_hit(wr, avs_address_i, OFS_STATUS_CONTROL_2);
	assign wr_cfg = reg_hit(wr, avs_address_i, OFS_CONFIG);
	assign wr_cvh = reg_hit(wr, avs_address_i, OFS_COMPARE_HIGH);
	assign wr_cvl = reg_hit(wr, avs_address_i, OFS_COMPARE_LOW);
	assign wr_pin = reg_hit(wr, avs_address_i, OFS_PIN_CONTROL_1);
	assign rd_hi  = reg_hit(rd, avs_address_i, OFS_RESULT_HIGH);
	assign rd_lo  = reg_hit(rd, avs_address_i, OFS_RESULT_LOW);

	assign core_low_power_o     = converter_config[CFG_LPC_BIT];
	assign core_clock_divider_o = converter_config[CFG_DIV_LSB +: 2];
	assign core_long_sample_o   = converter_config[CFG_LSMP_BIT];
	assign core_mode_o          = converter_config[CFG_MODE_LSB +: 2];
	assign core_clock_select_o  = converter_config[CFG_CLK_LSB +: 2];
	assign is_10bit             = core_mode_o == MODE_10BIT;
	assign core_channel_o       = sc1_ctrl[4:0];
	assign async_sel            = core_clock_select_o == ICLK_ASYNC;
	// bus-derived clocks stay enabled in wait
	assign core_bus_clock_enable_o = ~stop3_mode_i & ~stop12_mode_i;

	assign sw_start = wr_sc1 && ~sc2_trg && avs_writedata_i[4:0] != CH_DISABLED;
	// any control write except pin control changes the mode and invalidates a running conversion
	assign mode_change = wr_sc1 | wr_sc2 | wr_cfg | wr_cvh | wr_cvl;
	assign hwt_rise = hwt_sync[1] & ~hwt_sync[2];
	assign done_evt = done_sync[1] ^ done_sync[2];
	// stop3 entry without async clock aborts
	assign stop_abort = stop3_mode_i & ~stop3_q & ~async_sel;

	// add two's complement of compare value
	assign cmp_val = mask_res({compare_value_high[1:0], compare_value_low}, is_10bit);
	assign diff = {1'b0, data_q} + {1'b0, ~cmp_val} + 11'h001;
	// upper limit, lower limit, via carry out
	assign cmp_ok = ~sc2_cfe | (sc2_cfgt ? diff[10] : ~diff[10]);
	assign xfer_ok = cmp_ok & ~block_transfer;
	// only a passing, unblocked, undisturbed finish stores
	assign store_result = state == ST_FINISH && xfer_ok && !mode_change && !stop_abort;

	// trigger pin: two flops, third for the edge
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			hwt_sync <= 3'h0;
		end else begin
			hwt_sync <= {hwt_sync[1:0], hardware_trigger_i};
		end
	end

	// done toggle crosses from the converter clock
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			done_sync <= 3'h0;
		end else begin
			done_sync <= {done_sync[1:0], core_done_toggle_i};
		end
	end

	// stop3 level kept to find its entry
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			stop3_q <= 1'b0;
		end else begin
			stop3_q <= stop3_mode_i;
		end
	end

	// reads take one wait cycle
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rd_ack <= 1'b0;
		end else begin
			rd_ack <= avs_read_i & ~rd_ack;
		end
	end

	// stop1/stop2 returns every register to reset
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || stop12_mode_i) begin
			converter_config <= RST_BYTE;
		end else if (wr_cfg) begin
			converter_config <= avs_writedata_i[7:0];
		end
	end

	// control 1, flag bit is read-only
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || stop12_mode_i) begin
			sc1_ctrl <= RST_SC1;
		end else if (wr_sc1) begin
			sc1_ctrl <= {1'b0, avs_writedata_i[6:0]};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || stop12_mode_i) begin
			sc2_trg  <= 1'b0;
			sc2_cfe  <= 1'b0;
			sc2_cfgt <= 1'b0;
		end else if (wr_sc2) begin
			sc2_trg  <= avs_writedata_i[SC2_TRG_BIT];
			sc2_cfe  <= avs_writedata_i[SC2_CFE_BIT];
			sc2_cfgt <= avs_writedata_i[SC2_CFGT_BIT];
		end
	end

	// compare value high, two bits used
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || stop12_mode_i) begin
			compare_value_high <= RST_BYTE;
		end else if (wr_cvh) begin
			compare_value_high <= {6'h00, avs_writedata_i[1:0]};
		end
	end

	// compare value low byte
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || stop12_mode_i) begin
			compare_value_low <= RST_BYTE;
		end else if (wr_cvl) begin
			compare_value_low <= avs_writedata_i[7:0];
		end
	end

	// pin control byte
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || stop12_mode_i) begin
			pin_control_1_o <= RST_BYTE;
		end else if (wr_pin) begin
			pin_control_1_o <= avs_writedata_i[7:0];
		end
	end

	// conversion sequencer
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || stop12_mode_i) begin
			state        <= ST_IDLE;
			core_start_o <= 1'b0;
			core_abort_o <= 1'b0;
			data_q       <= 10'h000;
		end else begin
			core_start_o <= 1'b0;
			core_abort_o <= 1'b0;
			if (mode_change || stop_abort) begin
				core_abort_o <= state != ST_IDLE;
				state        <= ST_IDLE;
				if (sw_start) begin
					core_start_o <= 1'b1;
					state        <= ST_CONVERT;
				end
			end else begin
				case (state)
					// hardware trigger may start in wait; ignored while converting
					ST_IDLE: begin
						if (sc2_trg && hwt_rise && ~(stop3_mode_i & ~async_sel)
							&& core_channel_o != CH_DISABLED) begin
							core_start_o <= 1'b1;
							state        <= ST_CONVERT;
						end
					end
					// with async clock conversions run through stop3
					ST_CONVERT: begin
						if (done_evt) begin
							data_q <= mask_res(core_data_i, is_10bit);
							state  <= ST_FINISH;
						end
					end
					ST_FINISH: begin
						if (sc1_ctrl[SC1_CONTINUOUS_CONVERSION_BIT] || (block_transfer && !(sc2_cfe && !cmp_ok))) begin
							core_start_o <= 1'b1;
							state        <= ST_CONVERT;
						end else begin
							state <= ST_IDLE;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// high read arms blocking in 10-bit mode, low read releases it
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || stop12_mode_i) begin
			block_transfer <= 1'b0;
		end else if (rd_hi && is_10bit) begin
			block_transfer <= 1'b1;
		end else if (rd_lo) begin
			block_transfer <= 1'b0;
		end
	end

	// completion flag: control writes other than pin control, and low read, clear it
	// failed compare leaves the flag clear
	// completion sets the flag in any run mode, set wins over a low read
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || stop12_mode_i) begin
			conversion_complete_flag <= 1'b0;
		end else if (store_result) begin
			conversion_complete_flag <= 1'b1;
		end else if (mode_change || rd_lo) begin
			conversion_complete_flag <= 1'b0;
		end
	end

	// stored value is the difference when comparing
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || stop12_mode_i) begin
			result_high <= RST_BYTE;
			result_low  <= RST_BYTE;
		end else if (store_result) begin
			if (sc2_cfe) begin
				result_high <= {6'h00, diff[9:8]};
				result_low  <= diff[7:0];
			end else begin
				result_high <= {6'h00, data_q[9:8]};
				result_low  <= data_q[7:0];
			end
		end
	end

	assign converter_irq_o = conversion_complete_flag & sc1_ctrl[SC1_COMPLETION_IRQ_ENABLE_BIT];

	// read mux, unmapped addresses give zero
	always_comb begin
		next_readdata = RST_BYTE;
		case (avs_address_i)
			OFS_CONFIG:           next_readdata = converter_config;
			// flag in bit 7 above the control bits
			OFS_STATUS_CONTROL_1: next_readdata = {conversion_complete_flag, sc1_ctrl[6:0]};
			OFS_STATUS_CONTROL_2: next_readdata = {state != ST_IDLE, sc2_trg, sc2_cfe, sc2_cfgt, 4'h0};
			OFS_RESULT_HIGH:      next_readdata = result_high;
			OFS_RESULT_LOW:       next_readdata = result_low;
			OFS_COMPARE_HIGH:     next_readdata = compare_value_high;
			OFS_COMPARE_LOW:      next_readdata = compare_value_low;
			OFS_PIN_CONTROL_1:    next_readdata = pin_control_1_o;
			default:              next_readdata = RST_BYTE;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (rd) begin
			avs_readdata_o <= {24'h000000, next_readdata};
		end
	end
endmodule
`default_nettype wire

/* sim/adccl_core_model.sv */
// behavioural analog core: answers each start after LAT bus cycles unless an abort comes in that cycle or before the done toggle
// assumes one clock; data settles one cycle before the done toggle
`timescale 1ns/1ns
`default_nettype none
module adccl_core_model #(
	parameter int LAT = 6
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       core_start_o,
	input  wire logic       core_abort_o,
	input  wire logic [9:0] sample_i,
	output logic            core_done_toggle_i,
	output logic [9:0]      core_data_i
);
	int cnt;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || core_abort_o) cnt <= 0;
		else if (core_start_o) cnt <= LAT;
		else if (cnt > 0) cnt <= cnt - 1;
	end
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			core_data_i <= 10'h000;
			core_done_toggle_i <= 1'b0;
		end else if (cnt == 2) core_data_i <= sample_i;
		else if (cnt == 1) core_done_toggle_i <= ~core_done_toggle_i;
	end
endmodule
`default_nettype wire

/* sim/adccl_monitor.sv */
// port checker for the converter compare and low-power control block
// assumes it is bound onto adccl_top and runs on the single bus clock
`timescale 1ns/1ns
`default_nettype none
module adccl_checker
	import adccl_pkg::*;
(
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic [4:0]  avs_address_i,
	input wire logic        avs_write_i,
	input wire logic        avs_read_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        wait_mode_i,
	input wire logic        stop3_mode_i,
	input wire logic        stop12_mode_i,
	input wire logic        core_start_o,
	input wire logic [4:0]  core_channel_o,
	input wire logic [1:0]  core_mode_o,
	input wire logic        core_long_sample_o,
	input wire logic        core_low_power_o,
	input wire logic [1:0]  core_clock_select_o,
	input wire logic [1:0]  core_clock_divider_o,
	input wire logic        core_bus_clock_enable_o,
	input wire logic [7:0]  pin_control_1_o,
	input wire logic        converter_irq_o
);
	logic       trg_hw;
	logic       irq_en;
	logic [7:0] wd;
	assign wd = avs_writedata_i[7:0];
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// shadow of trigger select and interrupt enable
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || stop12_mode_i) begin
			trg_hw <= 1'b0;
			irq_en <= 1'b0;
		end else if (avs_write_i) begin
			if (avs_address_i == OFS_STATUS_CONTROL_2) trg_hw <= wd[SC2_TRG_BIT];
			if (avs_address_i == OFS_STATUS_CONTROL_1) irq_en <= wd[SC1_COMPLETION_IRQ_ENABLE_BIT];
		end
	end
	a_sw_start: assert property (
		avs_write_i && avs_address_i == OFS_STATUS_CONTROL_1 && wd[4:0] != CH_DISABLED && !trg_hw
		&& !stop3_mode_i && !stop12_mode_i |=> core_start_o) else $error("no start after control write");
	a_no_start_off: assert property (
		avs_write_i && avs_address_i == OFS_STATUS_CONTROL_1 && wd[4:0] == CH_DISABLED && !trg_hw
		|=> !core_start_o) else $error("start with channel all ones");
	a_cfg_fields: assert property (
		avs_write_i && avs_address_i == OFS_CONFIG && !stop12_mode_i |=> {core_low_power_o, core_clock_divider_o,
		core_long_sample_o, core_mode_o, core_clock_select_o} == $past(wd)) else $error("config fields misplaced");
	a_chan_field: assert property (
		avs_write_i && avs_address_i == OFS_STATUS_CONTROL_1 && !stop12_mode_i
		|=> {3'b000, core_channel_o} == ($past(wd) & 8'h1F)) else $error("channel field wrong");
	a_pin_ctl: assert property (
		avs_write_i && avs_address_i == OFS_PIN_CONTROL_1 |=> pin_control_1_o == $past(wd))
		else $error("pin control not stored");
	a_stop12_clear: assert property (
		stop12_mode_i |=> core_channel_o == CH_DISABLED && core_mode_o == MODE_8BIT && pin_control_1_o == 8'h00)
		else $error("registers not reset in deep stop");
	a_wait_clock: assert property (
		wait_mode_i && !stop3_mode_i && !stop12_mode_i |-> core_bus_clock_enable_o) else $error("clock off in wait");
	a_stop_clock_off: assert property (
		stop3_mode_i |-> !core_bus_clock_enable_o) else $error("bus clock kept in stop3");
	a_sc2_low_zero: assert property (
		avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_STATUS_CONTROL_2 |-> avs_readdata_o[1:0] == 2'b00)
		else $error("unimplemented bits not zero");
	a_irq_no_enable: assert property (
		!irq_en |-> !converter_irq_o) else $error("interrupt while disabled");
endmodule
`default_nettype wire

/* sim/test_adccl_top.sv */
// self-checking bench for the converter compare and low-power control block
// assumes the core model and the port checker are compiled before it
`timescale 1ns/1ns
`default_nettype none
module test_adccl_top;
	import adccl_pkg::*;
	logic        sys_clk_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0, hardware_trigger_i = 0;
	logic        wait_mode_i = 0, stop3_mode_i = 0, stop12_mode_i = 0, en, dir, completion_irq_enable;
	logic        avs_waitrequest_o, core_start_o, core_abort_o, core_done_toggle_i, converter_irq_o;
	logic [4:0]  avs_address_i = 0;
	logic [31:0] avs_writedata_i = 0, avs_readdata_o, r;
	logic [9:0]  core_data_i, sample_i = 0, cv, d, res;
	logic [10:0] e;
	logic [7:0]  q;
	int          num_errors = 0, check_count = 0, seed = 43, i;
	adccl_top dut_u (.*, .core_channel_o(), .core_mode_o(), .core_long_sample_o(), .core_low_power_o(),
		.core_clock_select_o(), .core_clock_divider_o(), .core_bus_clock_enable_o(), .pin_control_1_o());
	adccl_core_model #(.LAT(6)) model_u (.*);
	always #5 sys_clk_i = ~sys_clk_i;
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] wd);
		int  k;
		logic ws;
		avs_address_i <= a;
		avs_writedata_i <= {24'h0, wd};
		avs_write_i <= w;
		avs_read_i <= ~w;
		k = 0;
		do begin
			#1;
			ws = avs_waitrequest_o;
			q = avs_readdata_o[7:0];
			@(posedge sys_clk_i);
			k++;
		end while (ws !== 1'b0);
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	task automatic rd_chk(input string name, input logic [4:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(name, q, exp);
	endtask
	task automatic wait_done();
		logic t;
		int   k;
		#1;
		t = core_done_toggle_i;
		k = 0;
		while (core_done_toggle_i === t && k < 30) begin
			@(posedge sys_clk_i);
			#1;
			k++;
		end
		repeat (6) @(posedge sys_clk_i);
	endtask
	task automatic wait_pulse(input string name, ref logic s);
		int k;
		k = 0;
		do begin
			@(posedge sys_clk_i);
			#1;
			k++;
		end while (s !== 1'b1 && k < 10);
		check(name, k < 10, 1'b1);
		@(posedge sys_clk_i);
	endtask
	function automatic logic [10:0] expect_conv(input logic [9:0] dv, input logic [9:0] cmp, input logic ce,
		input logic up);
		logic [9:0] diff;
		diff = dv + (~cmp + 10'h001);
		if (!ce) return {1'b1, dv};
		if (up ? (dv >= cmp) : (dv < cmp)) return {1'b1, diff};
		return {1'b0, diff};
	endfunction
	task test_done();
		if (num_errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge sys_clk_i);
		num_errors++;
		test_done();
	end
	initial begin
		repeat (6) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_chk("sc1_reset", OFS_STATUS_CONTROL_1, RST_SC1);
		rd_chk("cfg_reset", OFS_CONFIG, RST_BYTE);
		rd_chk("unmapped", 5'h02, 8'h00);
		bus(1'b1, OFS_PIN_CONTROL_1, 8'h02);
		bus(1'b1, OFS_CONFIG, 8'h98);
		rd_chk("cfg", OFS_CONFIG, 8'h98);
		bus(1'b1, OFS_STATUS_CONTROL_2, 8'h33);
		rd_chk("sc2", OFS_STATUS_CONTROL_2, 8'h30);
		res = 10'h000;
		for (i = 0; i < 14; i++) begin
			r = $random(seed);
			{d, cv, completion_irq_enable, dir, en} = r[22:0];
			if (i < 4) en = 1'b1;
			if (i < 4) dir = i[0];
			if (i < 2) d = cv;
			sample_i <= d;
			bus(1'b1, OFS_STATUS_CONTROL_2, {2'b00, en, dir, 4'h0});
			bus(1'b1, OFS_COMPARE_HIGH, {6'h00, cv[9:8]});
			bus(1'b1, OFS_COMPARE_LOW, cv[7:0]);
			bus(1'b1, OFS_STATUS_CONTROL_1, {1'b0, completion_irq_enable, 6'h01});
			wait_mode_i <= i[0];
			wait_done();
			e = expect_conv(d, cv, en, dir);
			if (e[10]) res = e[9:0];
			check("irq", converter_irq_o, e[10] & completion_irq_enable);
			wait_mode_i <= 1'b0;
			rd_chk("sc1_flag", OFS_STATUS_CONTROL_1, {e[10], completion_irq_enable, 6'h01});
			rd_chk("res_hi", OFS_RESULT_HIGH, {6'h00, res[9:8]});
			rd_chk("res_lo", OFS_RESULT_LOW, res[7:0]);
		end
		bus(1'b1, OFS_STATUS_CONTROL_2, 8'h40);
		bus(1'b1, OFS_STATUS_CONTROL_1, 8'h41);
		sample_i <= 10'h2A5;
		wait_mode_i <= 1'b1;
		hardware_trigger_i <= 1'b1;
		wait_pulse("hw_start", core_start_o);
		wait_done();
		hardware_trigger_i <= 1'b0;
		wait_mode_i <= 1'b0;
		check("hw_irq", converter_irq_o, 1'b1);
		rd_chk("blk_hi", OFS_RESULT_HIGH, 8'h02);
		sample_i <= 10'h15A;
		hardware_trigger_i <= 1'b1;
		wait_done();
		rd_chk("blk_lo", OFS_RESULT_LOW, 8'hA5);
		hardware_trigger_i <= 1'b0;
		bus(1'b1, OFS_STATUS_CONTROL_1, 8'h1F);
		bus(1'b1, OFS_STATUS_CONTROL_2, 8'h00);
		bus(1'b1, OFS_STATUS_CONTROL_1, 8'h41);
		stop3_mode_i <= 1'b1; // blocking released by the low read above
		wait_pulse("stop3_abort", core_abort_o);
		repeat (12) @(posedge sys_clk_i);
		stop3_mode_i <= 1'b0;
		check("stop3_irq", converter_irq_o, 1'b0);
		rd_chk("stop3_sc1", OFS_STATUS_CONTROL_1, 8'h41);
		stop12_mode_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		stop12_mode_i <= 1'b0;
		@(posedge sys_clk_i);
		rd_chk("stop12_cfg", OFS_CONFIG, RST_BYTE);
		rd_chk("stop12_sc1", OFS_STATUS_CONTROL_1, RST_SC1);
		test_done();
	end
endmodule
bind adccl_top adccl_checker chk_u (.*);
`default_nettype wire
